// >>> osp_defs.svh
// Register offsets, field positions, reset values and counts for the
// oscillator select and PLL translation block.
// Included by bare name; definitions only.
`ifndef OSP_DEFS_SVH
`define OSP_DEFS_SVH

`define OSP_OFS_RCC        8'h60
`define OSP_OFS_XLAT       8'h64
`define OSP_OFS_FREQ       8'h68

`define OSP_BIT_MAIN_OFF   0
`define OSP_BIT_CHIP_OFF   1
`define OSP_RSV_HI         3
`define OSP_RSV_LO         2
`define OSP_SRC_HI         5
`define OSP_SRC_LO         4
`define OSP_CRYSTAL_SELECT_HI        9
`define OSP_CRYSTAL_SELECT_LO        6
`define OSP_BIT_BYPASS     11

`define OSP_MULT_HI        13
`define OSP_MULT_LO        5
`define OSP_DIV_HI         4
`define OSP_DIV_LO         0

`define OSP_FREQ_HI        25
`define OSP_BIT_BUSY       31

`define OSP_RST_SRC        2'h1
`define OSP_RST_CRYSTAL_SELECT       4'hb
`define OSP_RST_MAIN_OFF   1'b1
`define OSP_RST_CHIP_OFF   1'b0
`define OSP_RST_BYPASS     1'b1
`define OSP_RSV_VALUE      2'h0

`define OSP_DIV_STEPS      5'h1a
`define OSP_SLOW_KHZ       17'h0_001e

`endif

// >>> osp_pkg.sv
// Types shared by the oscillator select and PLL translation block.
// No assumptions beyond a SystemVerilog compiler.
package osp_pkg;
  typedef enum logic [1:0] {OSC_MAIN, OSC_CHIP, OSC_CHIP_DIV4, OSC_SLOW} osp_osc_e;
  typedef enum logic [2:0] {SYS_MAIN, SYS_CHIP, SYS_CHIP_DIV4, SYS_SLOW, SYS_PLL} osp_sys_e;
  typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_DIV} osp_state_e;
  typedef logic [8:0]  osp_mult_t;
  typedef logic [4:0]  osp_div_t;
  typedef logic [13:0] osp_khz_t;
endpackage : osp_pkg

// >>> osp_crystal_select_lut.sv
// Fixed crystal code to PLL multiplier and divider table.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ps
module osp_crystal_select_lut
  import osp_pkg::*;
(
  input  wire logic [3:0] crystal_select,
  output osp_mult_t       mult,
  output osp_div_t        div,
  output osp_khz_t        crystal_select_khz
);
  // Entries aim at a nominal PLL output near 400 MHz
  always_comb begin
    unique case (crystal_select)
      4'h0: begin mult = 9'h190; div = 5'h00; crystal_select_khz = 14'h03e8; end
      4'h1: begin mult = 9'h0d9; div = 5'h00; crystal_select_khz = 14'h0733; end
      4'h2: begin mult = 9'h0c8; div = 5'h00; crystal_select_khz = 14'h07d0; end
      4'h3: begin mult = 9'h0a3; div = 5'h00; crystal_select_khz = 14'h099a; end
      4'h4: begin mult = 9'h070; div = 5'h00; crystal_select_khz = 14'h0dfc; end
      4'h5: begin mult = 9'h0d9; div = 5'h01; crystal_select_khz = 14'h0e66; end
      4'h6: begin mult = 9'h064; div = 5'h00; crystal_select_khz = 14'h0fa0; end
      4'h7: begin mult = 9'h187; div = 5'h03; crystal_select_khz = 14'h1000; end
      4'h8: begin mult = 9'h197; div = 5'h04; crystal_select_khz = 14'h1333; end
      4'h9: begin mult = 9'h050; div = 5'h00; crystal_select_khz = 14'h1388; end
      4'ha: begin mult = 9'h139; div = 5'h03; crystal_select_khz = 14'h1400; end
      4'hb: begin mult = 9'h0c8; div = 5'h02; crystal_select_khz = 14'h1770; end
      4'hc: begin mult = 9'h146; div = 5'h04; crystal_select_khz = 14'h1800; end
      4'hd: begin mult = 9'h0d9; div = 5'h03; crystal_select_khz = 14'h1ccd; end
      4'he: begin mult = 9'h032; div = 5'h00; crystal_select_khz = 14'h1f40; end
      4'hf: begin mult = 9'h1e8; div = 5'h09; crystal_select_khz = 14'h2000; end
    endcase
  end
endmodule : osp_crystal_select_lut

// >>> osp_clk_route.sv
// System clock source routing and oscillator enables.
// Combinational; the top registers every output.
`timescale 1ns/1ps
module osp_clk_route
  import osp_pkg::*;
(
  input  osp_osc_e  osc_src,
  input  wire logic bypass,
  input  wire logic main_crystal_off,
  input  wire logic on_chip_clock_off,
  output osp_sys_e  sys_sel,
  output logic      main_en,
  output logic      chip_en
);
  always_comb begin
    main_en = !main_crystal_off;
    chip_en = !on_chip_clock_off;
    if (!bypass) begin
      sys_sel = SYS_PLL;
    end else begin
      unique case (osc_src)
        OSC_MAIN:      sys_sel = SYS_MAIN;
        OSC_CHIP:      sys_sel = SYS_CHIP;
        OSC_CHIP_DIV4: sys_sel = SYS_CHIP_DIV4;
        OSC_SLOW:      sys_sel = SYS_SLOW;
      endcase
    end
  end
endmodule : osp_clk_route

// >>> osp_clock_ctrl.sv
// Run-mode clock configuration, crystal to PLL translation and a
// computed PLL output frequency, behind a classic Wishbone slave.
// Assumes inputs synchronous to core_clk and a single-cycle master.
`timescale 1ns/1ps
`include "osp_defs.svh"
module osp_clock_ctrl
  import osp_pkg::*;
#(
  parameter logic [16:0] CHIP_KHZ = 17'h0_2ee0
) (
  input  wire logic        core_clk,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  output logic             main_osc_en,
  output logic             on_chip_osc_en,
  output logic      [1:0]  osc_src_sel,
  output logic      [2:0]  sys_clk_sel,
  output logic             pll_bypass,
  output logic      [8:0]  pll_mult,
  output logic      [4:0]  pll_div
);

  // Bus slave state
  logic        ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;

  // Configuration register fields
  logic        main_off_q, main_off_d;
  logic        chip_off_q, chip_off_d;
  osp_osc_e    src_q, src_d;
  logic [3:0]  crystal_select_q, crystal_select_d;
  logic        bypass_q, bypass_d;

  // Translation register and the code it was built from
  osp_mult_t   mult_q, mult_d;
  osp_div_t    div_q, div_d;
  logic [3:0]  xlat_code_q, xlat_code_d;
  logic        xlat_valid_q, xlat_valid_d;

  // Frequency calculation state
  osp_state_e  state_q, state_d;
  logic [4:0]  step_q, step_d;
  logic [6:0]  rem_q, rem_d;
  logic [25:0] quo_q, quo_d;
  logic [5:0]  dvsr_q, dvsr_d;
  logic [5:0]  tag_q, tag_d;
  logic [25:0] freq_q, freq_d;

  // Registered outputs
  logic        main_en_q, main_en_d;
  logic        chip_en_q, chip_en_d;
  logic [2:0]  sys_sel_q, sys_sel_d;

  osp_mult_t   lut_mult;
  osp_div_t    lut_div;
  osp_khz_t    lut_khz;
  osp_sys_e    route_sel;
  logic        route_main_en;
  logic        route_chip_en;

  logic        bus_req;
  logic        bus_wr;
  logic        hit_rcc;
  logic        hit_xlat;
  logic        hit_freq;
  logic [31:0] rcc_view;
  logic [31:0] xlat_view;
  logic [31:0] freq_view;
  logic [16:0] osc_khz;
  logic [25:0] product;
  logic [5:0]  cur_tag;
  logic [6:0]  trial;

  osp_crystal_select_lut u_lut (
    .crystal_select (crystal_select_q),
    .mult           (lut_mult),
    .div            (lut_div),
    .crystal_select_khz       (lut_khz)
  );

  osp_clk_route u_route (
    .osc_src           (src_q),
    .bypass            (bypass_q),
    .main_crystal_off  (main_off_q),
    .on_chip_clock_off (chip_off_q),
    .sys_sel           (route_sel),
    .main_en           (route_main_en),
    .chip_en           (route_chip_en)
  );

  // One wait state: ack follows the request by one edge and drops after
  assign bus_req  = wb_cyc_i && wb_stb_i && !ack_q;
  assign bus_wr   = bus_req && wb_we_i;
  assign hit_rcc  = (wb_adr_i == `OSP_OFS_RCC);
  assign hit_xlat = (wb_adr_i == `OSP_OFS_XLAT);
  assign hit_freq = (wb_adr_i == `OSP_OFS_FREQ);

  always_comb begin
    rcc_view = 32'h0000_0000;
    rcc_view[`OSP_BIT_MAIN_OFF] = main_off_q;
    rcc_view[`OSP_BIT_CHIP_OFF] = chip_off_q;
    rcc_view[`OSP_RSV_HI:`OSP_RSV_LO] = `OSP_RSV_VALUE;
    rcc_view[`OSP_SRC_HI:`OSP_SRC_LO] = src_q;
    rcc_view[`OSP_CRYSTAL_SELECT_HI:`OSP_CRYSTAL_SELECT_LO] = crystal_select_q;
    rcc_view[`OSP_BIT_BYPASS] = bypass_q;
    xlat_view = 32'h0000_0000;
    xlat_view[`OSP_MULT_HI:`OSP_MULT_LO] = mult_q;
    xlat_view[`OSP_DIV_HI:`OSP_DIV_LO] = div_q;
    freq_view = 32'h0000_0000;
    freq_view[`OSP_FREQ_HI:0] = freq_q;
    freq_view[`OSP_BIT_BUSY] = (state_q != ST_IDLE);
  end

  always_comb begin
    ack_d = bus_req;
    rdata_d = rdata_q;
    if (bus_req && !wb_we_i) begin
      if (hit_rcc) begin
        rdata_d = rcc_view;
      end else if (hit_xlat) begin
        rdata_d = xlat_view;
      end else if (hit_freq) begin
        rdata_d = freq_view;
      end else begin
        rdata_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // Configuration register writes, byte lane by byte lane
  always_comb begin
    main_off_d = main_off_q;
    chip_off_d = chip_off_q;
    src_d      = src_q;
    crystal_select_d     = crystal_select_q;
    bypass_d   = bypass_q;
    if (bus_wr && hit_rcc) begin
      if (wb_sel_i[0]) begin
        main_off_d = wb_dat_i[`OSP_BIT_MAIN_OFF];
        chip_off_d = wb_dat_i[`OSP_BIT_CHIP_OFF];
        src_d      = osp_osc_e'(wb_dat_i[`OSP_SRC_HI:`OSP_SRC_LO]);
        crystal_select_d[1:0] = wb_dat_i[7:`OSP_CRYSTAL_SELECT_LO];
      end
      if (wb_sel_i[1]) begin
        crystal_select_d[3:2] = wb_dat_i[`OSP_CRYSTAL_SELECT_HI:8];
        bypass_d    = wb_dat_i[`OSP_BIT_BYPASS];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      main_off_q <= `OSP_RST_MAIN_OFF;
      chip_off_q <= `OSP_RST_CHIP_OFF;
      src_q      <= osp_osc_e'(`OSP_RST_SRC);
      crystal_select_q     <= `OSP_RST_CRYSTAL_SELECT;
      bypass_q   <= `OSP_RST_BYPASS;
    end else begin
      main_off_q <= main_off_d;
      chip_off_q <= chip_off_d;
      src_q      <= src_d;
      crystal_select_q     <= crystal_select_d;
      bypass_q   <= bypass_d;
    end
  end

  // Translation follows the crystal code one edge after it changes;
  // bus writes to the translation offset never reach these flops
  always_comb begin
    mult_d       = mult_q;
    div_d        = div_q;
    xlat_code_d  = xlat_code_q;
    xlat_valid_d = 1'b1;
    if (!xlat_valid_q || (xlat_code_q != crystal_select_q)) begin
      mult_d      = lut_mult;
      div_d       = lut_div;
      xlat_code_d = crystal_select_q;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mult_q       <= 9'h000;
      div_q        <= 5'h00;
      xlat_code_q  <= 4'h0;
      xlat_valid_q <= 1'b0;
    end else begin
      mult_q       <= mult_d;
      div_q        <= div_d;
      xlat_code_q  <= xlat_code_d;
      xlat_valid_q <= xlat_valid_d;
    end
  end

  // Frequency of the selected oscillator in kHz
  always_comb begin
    unique case (src_q)
      OSC_MAIN:      osc_khz = {3'h0, lut_khz};
      OSC_CHIP:      osc_khz = CHIP_KHZ;
      OSC_CHIP_DIV4: osc_khz = {2'h0, CHIP_KHZ[16:2]};
      OSC_SLOW:      osc_khz = `OSP_SLOW_KHZ;
    endcase
  end

  // Widen both operands first: a self-sized 17-bit product would wrap
  assign product = 26'(osc_khz) * 26'(mult_q);
  // Tag holds the code itself so a change during a divide is not lost
  assign cur_tag = {xlat_code_q, src_q};
  assign trial   = {rem_q[5:0], quo_q[25]};

  // Serial restoring divide keeps area small at the cost of 26 cycles
  always_comb begin
    state_d = state_q;
    step_d  = step_q;
    rem_d   = rem_q;
    quo_d   = quo_q;
    dvsr_d  = dvsr_q;
    tag_d   = tag_q;
    freq_d  = freq_q;
    unique case (state_q)
      ST_INIT: begin
        if (xlat_valid_q && (xlat_code_q == crystal_select_q)) begin
          state_d = ST_IDLE;
          tag_d   = ~cur_tag;
        end
      end
      ST_IDLE: begin
        if ((tag_q != cur_tag) && xlat_valid_q && (xlat_code_q == crystal_select_q)) begin
          state_d = ST_DIV;
          step_d  = 5'h00;
          rem_d   = 7'h00;
          quo_d   = product;
          dvsr_d  = {1'b0, div_q} + 6'h01;
          tag_d   = cur_tag;
        end else if (xlat_code_q != crystal_select_q) begin
          tag_d = cur_tag;
        end
      end
      ST_DIV: begin
        if (trial >= {1'b0, dvsr_q}) begin
          rem_d = trial - {1'b0, dvsr_q};
          quo_d = {quo_q[24:0], 1'b1};
        end else begin
          rem_d = trial;
          quo_d = {quo_q[24:0], 1'b0};
        end
        step_d = step_q + 5'h01;
        if (step_q == (`OSP_DIV_STEPS - 5'h01)) begin
          state_d = ST_IDLE;
          freq_d  = quo_d;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_q <= ST_INIT;
      step_q  <= 5'h00;
      rem_q   <= 7'h00;
      quo_q   <= 26'h000_0000;
      dvsr_q  <= 6'h01;
      tag_q   <= 6'h00;
      freq_q  <= 26'h000_0000;
    end else begin
      state_q <= state_d;
      step_q  <= step_d;
      rem_q   <= rem_d;
      quo_q   <= quo_d;
      dvsr_q  <= dvsr_d;
      tag_q   <= tag_d;
      freq_q  <= freq_d;
    end
  end

  // Outputs to the oscillators and the clock mux
  always_comb begin
    main_en_d = route_main_en;
    chip_en_d = route_chip_en;
    sys_sel_d = route_sel;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      main_en_q <= !`OSP_RST_MAIN_OFF;
      chip_en_q <= !`OSP_RST_CHIP_OFF;
      sys_sel_q <= SYS_CHIP;
    end else begin
      main_en_q <= main_en_d;
      chip_en_q <= chip_en_d;
      sys_sel_q <= sys_sel_d;
    end
  end

  assign wb_ack_o       = ack_q;
  assign wb_dat_o       = rdata_q;
  assign main_osc_en    = main_en_q;
  assign on_chip_osc_en = chip_en_q;
  assign osc_src_sel    = src_q;
  assign sys_clk_sel    = sys_sel_q;
  assign pll_bypass     = bypass_q;
  assign pll_mult       = mult_q;
  assign pll_div        = div_q;

endmodule : osp_clock_ctrl

// >>> osp_clock_ctrl_props.sv
// Concurrent checks on the ports of the clock control block.
// Assumes a classic single-cycle Wishbone master that drops stb after each ack.
`timescale 1ns/1ps
module osp_chk
  import osp_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        main_osc_en,
  input wire logic        on_chip_osc_en,
  input wire logic [1:0]  osc_src_sel,
  input wire logic [2:0]  sys_clk_sel,
  input wire logic        pll_bypass,
  input wire logic [8:0]  pll_mult,
  input wire logic [4:0]  pll_div
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  logic take;
  logic cfg_wr;
  assign take   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign cfg_wr = take && wb_we_i && (wb_adr_i == 8'h60);

  ack_one_cycle_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not a single pulse one cycle after request");
  src_field_a: assert property (cfg_wr && wb_sel_i[0] |=> osc_src_sel == $past(wb_dat_i[5:4]))
    else $error("source select does not follow write");
  chip_osc_en_a: assert property (cfg_wr && wb_sel_i[0] |-> ##2 on_chip_osc_en == !$past(wb_dat_i[1], 2))
    else $error("internal oscillator enable wrong after write");
  main_osc_en_a: assert property (cfg_wr && wb_sel_i[0] |-> ##2 main_osc_en == !$past(wb_dat_i[0], 2))
    else $error("main oscillator enable wrong after write");
  xlat_reload_a: assert property (cfg_wr && wb_sel_i == 4'h3 && wb_dat_i[9:6] == 4'hf
    |-> ##2 pll_mult == 9'h1e8 && pll_div == 5'h09) else $error("translation not reloaded");
  xlat_reset_a: assert property ($rose(resetn) |=> pll_mult == 9'h0c8 && pll_div == 5'h02)
    else $error("translation not loaded after reset");
  xlat_ro_a: assert property (take && wb_we_i && wb_adr_i == 8'h64 |=> $stable(pll_mult) && $stable(pll_div))
    else $error("write changed translation");
  xlat_read_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h64
    |-> wb_dat_o == {18'h0_0000, pll_mult, pll_div}) else $error("translation read differs");
  rsv_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h60 |-> wb_dat_o[3:2] == 2'h0)
    else $error("reserved bits read nonzero");
  bypass_bit_a: assert property (cfg_wr && wb_sel_i[1] |=> pll_bypass == $past(wb_dat_i[11]))
    else $error("bypass does not follow write");
  sys_sel_a: assert property (1'b1 |=> sys_clk_sel ==
    ($past(pll_bypass) ? {1'b0, $past(osc_src_sel)} : 3'h4)) else $error("system clock select wrong");
endmodule : osp_chk

bind osp_clock_ctrl osp_chk chk_u (.core_clk(core_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .main_osc_en(main_osc_en),
  .on_chip_osc_en(on_chip_osc_en), .osc_src_sel(osc_src_sel), .sys_clk_sel(sys_clk_sel),
  .pll_bypass(pll_bypass), .pll_mult(pll_mult), .pll_div(pll_div));

// >>> osp_tb.sv
// Self-checking bench for the clock control block, driven over Wishbone.
// Assumes the default internal oscillator rate of 12000 kHz.
`timescale 1ns/1ps
module tb;
  import osp_pkg::*;
  logic        core_clk = 1'b0;
  logic        resetn   = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i  = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [3:0]  wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        main_osc_en;
  logic        on_chip_osc_en;
  logic [1:0]  osc_src_sel;
  logic [2:0]  sys_clk_sel;
  logic        pll_bypass;
  logic [8:0]  pll_mult;
  logic [4:0]  pll_div;
  int          errors    = 0;
  int          tests_run = 0;
  logic [31:0] rd;
  logic [31:0] cfg;
  // Expected {multiplier, divider} per crystal code
  logic [13:0] xl_tbl [16] = '{14'h3200, 14'h1b20, 14'h1900, 14'h1460, 14'h0e00, 14'h1b21,
    14'h0c80, 14'h30e3, 14'h32e4, 14'h0a00, 14'h2723, 14'h1902, 14'h28c4, 14'h1b23,
    14'h0640, 14'h3d09};

  always #5 core_clk = ~core_clk;

  osp_clock_ctrl dut_u (.core_clk(core_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .main_osc_en(main_osc_en),
    .on_chip_osc_en(on_chip_osc_en), .osc_src_sel(osc_src_sel), .sys_clk_sel(sys_clk_sel),
    .pll_bypass(pll_bypass), .pll_mult(pll_mult), .pll_div(pll_div));

  task automatic end_sim;
    if (errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                         input logic [31:0] wd, output logic [31:0] rdat);
    int n;
    n = 0;
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= wd;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      errors++;
      end_sim();
    end
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb_xfer

  // Polls until the busy flag is clear and the value settled; a stale result is not a pass
  task automatic wait_freq(input logic [31:0] exp);
    int n;
    logic [31:0] v;
    n = 0;
    do begin
      wb_xfer(1'b0, 8'h68, 4'hf, 32'h0000_0000, v);
      n++;
    end while ((v[31] !== 1'b0 || v !== exp) && n < 100);
    if (v !== exp) begin
      errors++;
      end_sim();
    end
    chk("freq", v, exp);
  endtask : wait_freq

  task automatic chk_reset_state;
    wb_xfer(1'b0, 8'h60, 4'hf, 32'h0000_0000, rd);
    chk("cfg_rst", rd, 32'h0000_0ad1);
    chk("xlat_rst", 32'({pll_mult, pll_div}), 32'h0000_1902);
  endtask : chk_reset_state

  initial begin
    repeat (12) @(posedge core_clk);
    chk("en_rst", 32'({main_osc_en, on_chip_osc_en, osc_src_sel, pll_bypass}), 32'h0000_000b);
    resetn <= 1'b1;
    chk_reset_state();
    wait_freq(32'h000c_3500);
    for (int i = 0; i < 16; i++) begin
      cfg = 32'({i[2], 1'b0, i[3:0], i[1:0], 2'b11, i[1], i[0]});
      wb_xfer(1'b1, 8'h60, 4'h3, cfg, rd);
      wb_xfer(1'b0, 8'h60, 4'hf, 32'h0000_0000, rd);
      chk("cfg", rd, cfg & 32'h0000_0bf3);
      wb_xfer(1'b0, 8'h64, 4'hf, 32'h0000_0000, rd);
      chk("xlat", rd, 32'(xl_tbl[i]));
      chk("mult_div", 32'({pll_mult, pll_div}), 32'(xl_tbl[i]));
      chk("src", 32'(osc_src_sel), 32'(i[1:0]));
      chk("main_en", 32'(main_osc_en), 32'(!i[0]));
      chk("chip_en", 32'(on_chip_osc_en), 32'(!i[1]));
      chk("sys_sel", 32'(sys_clk_sel), i[2] ? 32'(i[1:0]) : 32'h0000_0004);
    end
    wb_xfer(1'b1, 8'h64, 4'hf, 32'hffff_ffff, rd);
    wb_xfer(1'b0, 8'h64, 4'hf, 32'h0000_0000, rd);
    chk("xlat_ro", rd, 32'h0000_3d09);
    wb_xfer(1'b1, 8'h7c, 4'hf, 32'hffff_ffff, rd);
    wb_xfer(1'b0, 8'h7c, 4'hf, 32'h0000_0000, rd);
    chk("unmapped", rd, 32'h0000_0000);
    // Upper lane only: crystal code drops from 0xF to 0x3
    wb_xfer(1'b1, 8'h60, 4'h2, 32'h0000_0000, rd);
    wb_xfer(1'b0, 8'h60, 4'hf, 32'h0000_0000, rd);
    chk("cfg_lane", rd, 32'h0000_00f3);
    wb_xfer(1'b0, 8'h64, 4'hf, 32'h0000_0000, rd);
    chk("xlat_lane", rd, 32'h0000_1460);
    wb_xfer(1'b1, 8'h60, 4'h3, 32'h0000_0bc0, rd);
    wait_freq(32'h0006_1999);
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    chk_reset_state();
    end_sim();
  end
endmodule : tb
